//--- hdl/port_status_copper_basic_control.sv
// apb register slave for port status and copper basic control
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module port_status_copper_basic_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic copper_port,
   input wire logic strap_autoneg,
   input wire logic [1:0] strap_speed,
   input wire logic link_up,
   input wire logic [1:0] link_speed,
   input wire logic link_duplex,
   input wire logic [1:0] adv_pause,
   input wire logic pause_agreed_tx,
   input wire logic pause_agreed_rx,
   input wire logic [7:0] parallel_if_control_first,
   input wire logic [7:0] parallel_if_control_second,
   output logic phy_soft_reset,
   output logic local_loopback,
   output logic [1:0] forced_speed,
   output logic forced_speed_active,
   output logic autoneg_enable
);

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic cu_s1;
      logic cu_s2;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic sw_reset;
      logic loopback;
      logic speed_msb;
      logic speed_lsb;
      logic an_en;
      logic forced_act;
   } state_t;

   state_t cur;
   state_t next_cur;
   link_state_if ls ();

   logic [15:0] ctrl_view;
   logic hit_status;
   logic hit_ctrl;
   logic acc_err;
   logic wr_done;

   // ---------------------------------------------------------------
   // status multiplexer
   // ---------------------------------------------------------------
   assign ls.copper = cur.cu_s2;
   assign ls.link_up = link_up;
   assign ls.link_speed = link_speed;
   assign ls.link_duplex = link_duplex;
   assign ls.adv_pause = adv_pause;
   assign ls.agreed_tx = pause_agreed_tx;
   assign ls.agreed_rx = pause_agreed_rx;
   assign ls.pif_first = parallel_if_control_first;
   assign ls.pif_second = parallel_if_control_second;

   link_state_mux u_mux (
      .ls(ls.mux)
   );

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   always_comb begin
      hit_status = 1'b0;
      hit_ctrl = 1'b0;
      if (paddr == port_regs_pkg::ADDR_LINK_STATE) begin
         hit_status = 1'b1;
      end else if (paddr == port_regs_pkg::ADDR_COPPER_CTRL) begin
         hit_ctrl = cur.cu_s2;
      end
      acc_err = ~(hit_status | hit_ctrl);
      wr_done = psel & penable & cur.ready & pwrite & ~cur.err;
   end

   // reset bit always reads back as zero since ctrl_view never maps it
   always_comb begin
      ctrl_view = '0;
      ctrl_view[port_regs_pkg::CTL_LOOPBACK] = cur.loopback;
      ctrl_view[port_regs_pkg::CTL_SPEED_LSB] = cur.speed_lsb;
      ctrl_view[port_regs_pkg::CTL_AN_EN] = cur.an_en;
      ctrl_view[port_regs_pkg::CTL_SPEED_MSB] = cur.speed_msb;
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_cur = cur;
      if (ce) begin
         next_cur.cu_s1 = copper_port;
         next_cur.cu_s2 = cur.cu_s1;
         next_cur.strap_s1 = {strap_autoneg, strap_speed};
         next_cur.strap_s2 = cur.strap_s1;
         next_cur.sw_reset = 1'b0;
         if (!cur.strap_done) begin
            if (cur.strap_cnt == port_regs_pkg::STRAP_SETTLE) begin
               next_cur.strap_done = 1'b1;
               next_cur.an_en = cur.strap_s2[2];
               next_cur.speed_msb = cur.strap_s2[1];
               next_cur.speed_lsb = cur.strap_s2[0];
            end else begin
               next_cur.strap_cnt = cur.strap_cnt + 2'h1;
            end
         end
         if (psel && penable && !cur.ready) begin
            next_cur.ready = 1'b1;
            next_cur.err = acc_err;
            if (pwrite || acc_err) begin
               next_cur.rdata = port_regs_pkg::DATA_ZERO;
            end else if (hit_status) begin
               next_cur.rdata = {24'h0, ls.status};
            end else begin
               next_cur.rdata = {16'h0, ctrl_view};
            end
         end else begin
            next_cur.ready = 1'b0;
            next_cur.err = 1'b0;
         end
         // status writes fall through with no effect
         if (wr_done && paddr == port_regs_pkg::ADDR_COPPER_CTRL) begin
            next_cur.sw_reset = pwdata[port_regs_pkg::CTL_SW_RESET];
            next_cur.loopback = pwdata[port_regs_pkg::CTL_LOOPBACK];
            next_cur.speed_lsb = pwdata[port_regs_pkg::CTL_SPEED_LSB];
            next_cur.speed_msb = pwdata[port_regs_pkg::CTL_SPEED_MSB];
            next_cur.an_en = pwdata[port_regs_pkg::CTL_AN_EN];
         end
         next_cur.forced_act = ~next_cur.an_en &
            ({next_cur.speed_msb, next_cur.speed_lsb} !=
             port_regs_pkg::SPEED_RSVD);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign prdata = cur.rdata;
   assign pready = cur.ready;
   assign pslverr = cur.err;
   assign phy_soft_reset = cur.sw_reset;
   assign local_loopback = cur.loopback;
   assign forced_speed = {cur.speed_msb, cur.speed_lsb};
   assign forced_speed_active = cur.forced_act;
   assign autoneg_enable = cur.an_en;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence seq_ctrl_write;
      ce && psel && penable && pready && pwrite && !pslverr &&
         paddr == port_regs_pkg::ADDR_COPPER_CTRL;
   endsequence

   sequence seq_status_read;
      ce && psel && penable && pready && !pwrite &&
         paddr == port_regs_pkg::ADDR_LINK_STATE;
   endsequence

   sequence seq_pulse_once;
      phy_soft_reset ##1 !phy_soft_reset;
   endsequence

   chk_status_upper_zero: assert property (
      seq_status_read |-> prdata[31:8] == 24'h0 && !pslverr)
      else $error("status reserved bits not zero");

   chk_soft_reset_pulse: assert property (
      seq_ctrl_write ##0 pwdata[15] ##1 ce |-> seq_pulse_once)
      else $error("soft reset not a single pulse");

   chk_loopback_write: assert property (
      seq_ctrl_write |=> local_loopback == $past(pwdata[14]))
      else $error("loopback bit not stored");

   chk_forced_speed_write: assert property (
      seq_ctrl_write |=>
         forced_speed == {$past(pwdata[6]), $past(pwdata[13])})
      else $error("forced speed bits not stored");

   chk_forced_ignored: assert property (
      autoneg_enable |-> !forced_speed_active)
      else $error("forced speed active under auto-negotiation");

   chk_an_enable_write: assert property (
      seq_ctrl_write |=> autoneg_enable == $past(pwdata[12]))
      else $error("auto-negotiation enable not stored");

   chk_copper_only: assert property (
      ce && psel && penable && !pready && !cur.cu_s2 &&
         paddr == port_regs_pkg::ADDR_COPPER_CTRL |=> pready && pslverr)
      else $error("copper register reachable on parallel port");

   chk_strap_load: assert property (
      $rose(cur.strap_done) |->
         {autoneg_enable, forced_speed} == $past(cur.strap_s2))
      else $error("strap values not loaded");

   chk_copper_speed: assert property (
      cur.cu_s2 |-> ls.status[4:3] == link_speed &&
         ls.status[2] == link_duplex)
      else $error("copper speed or duplex status wrong");

   chk_parallel_mirror: assert property (
      !cur.cu_s2 |-> ls.status[4:0] == {parallel_if_control_second[6],
         parallel_if_control_first[4], parallel_if_control_first[6],
         parallel_if_control_first[5], parallel_if_control_first[3]})
      else $error("parallel status does not mirror settings");

   chk_copper_pause: assert property (
      cur.cu_s2 && (!link_up || adv_pause == 2'h0) |->
         ls.status[1:0] == 2'h0)
      else $error("pause status set without link or advertisement");

   chk_answer_time: assert property (
      ce && psel && penable && !pready ##1 ce |-> pready ##1 !pready)
      else $error("apb answer not one wait state");

   chk_duplex_mirror: assert property (
      !cur.cu_s2 |-> ls.status[port_regs_pkg::ST_DUPLEX] ==
         parallel_if_control_first[port_regs_pkg::PIF0_DUPLEX])
      else $error("duplex status does not mirror setting");

   chk_tx_pause_mirror: assert property (
      !cur.cu_s2 |-> ls.status[port_regs_pkg::ST_TRANSMIT_PAUSE_ENABLE] ==
         parallel_if_control_first[port_regs_pkg::PIF0_TX_PAUSE])
      else $error("tx pause status does not mirror setting");

   chk_rx_pause_mirror: assert property (
      !cur.cu_s2 |-> ls.status[port_regs_pkg::ST_RECEIVE_PAUSE_ENABLE] ==
         parallel_if_control_first[port_regs_pkg::PIF0_RX_PAUSE])
      else $error("rx pause status does not mirror setting");

   chk_copper_duplex: assert property (
      cur.cu_s2 |-> ls.status[port_regs_pkg::ST_DUPLEX] == link_duplex)
      else $error("copper duplex status wrong");

   chk_copper_pause_on: assert property (
      cur.cu_s2 && link_up && adv_pause != 2'h0 |->
         ls.status[port_regs_pkg::ST_TRANSMIT_PAUSE_ENABLE] == pause_agreed_tx &&
         ls.status[port_regs_pkg::ST_RECEIVE_PAUSE_ENABLE] == pause_agreed_rx)
      else $error("agreed pause not shown on copper link");

   chk_status_write_none: assert property (
      cur.strap_done && ce && psel && penable && pready && pwrite &&
         paddr == port_regs_pkg::ADDR_LINK_STATE |=>
         $stable(local_loopback) && $stable(autoneg_enable) &&
         $stable(forced_speed))
      else $error("status write changed a control setting");

   chk_reset_from_write: assert property (
      $rose(phy_soft_reset) |->
         $past(psel && penable && pready && pwrite && !pslverr &&
         paddr == port_regs_pkg::ADDR_COPPER_CTRL) &&
         $past(pwdata[port_regs_pkg::CTL_SW_RESET]))
      else $error("soft reset pulse without a control write");

   chk_soft_reset_keeps: assert property (
      ce && phy_soft_reset && !(psel && penable && pready) |=>
         $stable(local_loopback) && $stable(autoneg_enable) &&
         $stable(forced_speed))
      else $error("soft reset changed register contents");

   chk_an_disable_write: assert property (
      seq_ctrl_write ##0 !pwdata[port_regs_pkg::CTL_AN_EN] |=>
         !autoneg_enable)
      else $error("auto-negotiation not disabled by write");

   sequence seq_ctrl_read;
      ce && psel && penable && pready && !pwrite && !pslverr &&
         paddr == port_regs_pkg::ADDR_COPPER_CTRL;
   endsequence

   chk_reset_reads_zero: assert property (
      seq_ctrl_read |-> !prdata[port_regs_pkg::CTL_SW_RESET] &&
         prdata[31:16] == 16'h0)
      else $error("control read shows reset bit or upper bits");

   chk_error_data_zero: assert property (
      pready && pslverr |-> prdata == port_regs_pkg::DATA_ZERO)
      else $error("refused access returned data");

   chk_ready_pulse: assert property (
      pready && ce |=> !pready)
      else $error("pready longer than one cycle");

   chk_ce_freeze: assert property (
      !ce |=> $stable(cur))
      else $error("state moved while clock enable low");

endmodule : port_status_copper_basic_control

//--- hdl/port_regs_pkg.sv
// constants and helpers for the port status and copper control registers
//
// Overview of operation
// - copper port speed status shows resolved speed: 00=10M, 01=100M, 10=1000M
// - parallel port speed status mirrors second control bit 6, first bit 4
// - copper port duplex status shows resolved duplex, 1 full, 0 half
// - parallel port duplex status mirrors first interface control bit 6
// - parallel port tx pause status bit 1 mirrors first control bit 5
// - parallel port rx pause status bit 0 mirrors first control bit 3
// - copper pause status needs advertised pause, link up and agreed pause
// - copper control register exists only on copper ports
// - writing control bit 15 resets transceiver only, then self-clears
// - control bit 14 loops egress traffic back into the fabric
// - forced speed is bits 6 and 13, ignored while auto-negotiation enabled
// - control bit 12 set enables auto-negotiation
// - bit 12 clear disables it; power-up value from strap, writable later
// - speed select power-up values come from the strap sampled at reset
package port_regs_pkg;

   // ---------------------------------------------------------------
   // register map (byte addresses)
   // ---------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [11:0] ADDR_LINK_STATE = 12'h030;
   localparam logic [11:0] ADDR_COPPER_CTRL = 12'h100;

   // ---------------------------------------------------------------
   // copper control field positions
   // ---------------------------------------------------------------
   localparam int CTL_SW_RESET = 15;
   localparam int CTL_LOOPBACK = 14;
   localparam int CTL_SPEED_LSB = 13;
   localparam int CTL_AN_EN = 12;
   localparam int CTL_SPEED_MSB = 6;

   // ---------------------------------------------------------------
   // status field positions
   // ---------------------------------------------------------------
   localparam int ST_SPEED_HI = 4;
   localparam int ST_SPEED_LO = 3;
   localparam int ST_DUPLEX = 2;
   localparam int ST_TRANSMIT_PAUSE_ENABLE = 1;
   localparam int ST_RECEIVE_PAUSE_ENABLE = 0;
   localparam int ST_W = 8;

   // ---------------------------------------------------------------
   // parallel interface control bits mirrored into status
   // ---------------------------------------------------------------
   localparam int PIF0_SPEED = 4;
   localparam int PIF0_DUPLEX = 6;
   localparam int PIF0_TX_PAUSE = 5;
   localparam int PIF0_RX_PAUSE = 3;
   localparam int PIF1_SPEED = 6;

   // ---------------------------------------------------------------
   // speed codes and timing
   // ---------------------------------------------------------------
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic [1:0] SPEED_RSVD = 2'h3;
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   localparam logic [31:0] DATA_ZERO = 32'h0;

   // pause status bit of one direction
   function automatic logic pause_status(input logic copper,
                                         input logic pif_bit,
                                         input logic [1:0] adv,
                                         input logic link_up,
                                         input logic agreed);
      if (copper) begin
         pause_status = (|adv) & link_up & agreed;
      end else begin
         pause_status = pif_bit;
      end
   endfunction : pause_status

endpackage : port_regs_pkg

//--- hdl/link_state_if.sv
// signals between the register slave and the status multiplexer
`timescale 1ns/1ps
interface link_state_if;
   logic copper;
   logic link_up;
   logic [1:0] link_speed;
   logic link_duplex;
   logic [1:0] adv_pause;
   logic agreed_tx;
   logic agreed_rx;
   logic [7:0] pif_first;
   logic [7:0] pif_second;
   logic [7:0] status;

   modport mux (
      input copper, link_up, link_speed, link_duplex, adv_pause,
      input agreed_tx, agreed_rx, pif_first, pif_second,
      output status
   );
   modport regs (
      output copper, link_up, link_speed, link_duplex, adv_pause,
      output agreed_tx, agreed_rx, pif_first, pif_second,
      input status
   );
endinterface : link_state_if

//--- hdl/link_state_mux.sv
// builds the port status byte from the link or the parallel settings
`timescale 1ns/1ps
module link_state_mux (
   link_state_if.mux ls
);
   always_comb begin
      ls.status = '0;
      if (ls.copper) begin
         ls.status[port_regs_pkg::ST_SPEED_HI:port_regs_pkg::ST_SPEED_LO] =
            ls.link_speed;
         ls.status[port_regs_pkg::ST_DUPLEX] = ls.link_duplex;
      end else begin
         ls.status[port_regs_pkg::ST_SPEED_HI] =
            ls.pif_second[port_regs_pkg::PIF1_SPEED];
         ls.status[port_regs_pkg::ST_SPEED_LO] =
            ls.pif_first[port_regs_pkg::PIF0_SPEED];
         ls.status[port_regs_pkg::ST_DUPLEX] =
            ls.pif_first[port_regs_pkg::PIF0_DUPLEX];
      end
      ls.status[port_regs_pkg::ST_TRANSMIT_PAUSE_ENABLE] = port_regs_pkg::pause_status(
         ls.copper, ls.pif_first[port_regs_pkg::PIF0_TX_PAUSE],
         ls.adv_pause, ls.link_up, ls.agreed_tx);
      ls.status[port_regs_pkg::ST_RECEIVE_PAUSE_ENABLE] = port_regs_pkg::pause_status(
         ls.copper, ls.pif_first[port_regs_pkg::PIF0_RX_PAUSE],
         ls.adv_pause, ls.link_up, ls.agreed_rx);
   end
endmodule : link_state_mux

//--- verification/port_status_copper_basic_control_tb_top.sv
// self-checking bench for the port status and copper control registers
`timescale 1ns/1ps
module port_status_copper_basic_control_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic copper_port = 1'b1;
   logic strap_autoneg = 1'b0;
   logic [1:0] strap_speed = 2'h2;
   logic link_up = 1'b0;
   logic [1:0] link_speed = 2'h0;
   logic link_duplex = 1'b0;
   logic [1:0] adv_pause = 2'h0;
   logic pause_agreed_tx = 1'b0;
   logic pause_agreed_rx = 1'b0;
   logic [7:0] pif_a = 8'h00;
   logic [7:0] pif_b = 8'h00;
   logic phy_soft_reset;
   logic local_loopback;
   logic [1:0] forced_speed;
   logic forced_speed_active;
   logic autoneg_enable;
   logic [1:0] sp;
   logic [3:0] b;
   logic [31:0] ctl;
   int mismatches = 0;
   int checked = 0;
   int pulses = 0;
   int p0;

   localparam logic [11:0] CTL = port_regs_pkg::ADDR_COPPER_CTRL;
   localparam logic [11:0] STS = port_regs_pkg::ADDR_LINK_STATE;

   always #2.5 pclk = ~pclk;

   always @(posedge pclk) begin
      if (phy_soft_reset === 1'b1) begin
         pulses++;
      end
   end

   port_status_copper_basic_control dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .copper_port(copper_port), .strap_autoneg(strap_autoneg),
      .strap_speed(strap_speed), .link_up(link_up),
      .link_speed(link_speed), .link_duplex(link_duplex),
      .adv_pause(adv_pause), .pause_agreed_tx(pause_agreed_tx),
      .pause_agreed_rx(pause_agreed_rx),
      .parallel_if_control_first(pif_a),
      .parallel_if_control_second(pif_b),
      .phy_soft_reset(phy_soft_reset), .local_loopback(local_loopback),
      .forced_speed(forced_speed),
      .forced_speed_active(forced_speed_active),
      .autoneg_enable(autoneg_enable)
   );

   // ---------------------------------------------------------------
   // checking and bus tasks
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen,
                        input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] addr,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic err);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      check("apb_answer", {31'h0, pready}, 32'h1);
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] addr, input logic [31:0] d,
                     input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b1, addr, d, r, e);
      check("write_error", {31'h0, e}, {31'h0, exp_err});
   endtask : wr

   task automatic rd(input string name, input logic [11:0] addr,
                     input logic [31:0] exp, input logic exp_err);
      logic [31:0] r;
      logic e;
      apb(1'b0, addr, 32'h0, r, e);
      check(name, r, exp);
      check({name, "_error"}, {31'h0, e}, {31'h0, exp_err});
   endtask : rd

   task automatic settle;
      repeat (2) @(posedge pclk);
   endtask : settle

   task automatic end_of_test;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (20000) @(posedge pclk);
      mismatches++;
      end_of_test();
   end

   // ---------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      rd("control_reset", CTL, 32'h0000_0040, 1'b0);
      check("autoneg_reset", {31'h0, autoneg_enable}, 32'h0);
      check("speed_reset", {30'h0, forced_speed}, 32'h2);
      $display("test strap_defaults done");
      for (int i = 0; i < 4; i++) begin
         sp = i[1:0];
         ctl = {16'h0, 2'b00, sp[0], 1'b0, 5'h00, sp[1], 6'h00};
         wr(CTL, ctl, 1'b0);
         settle();
         check("forced_speed", {30'h0, forced_speed}, {30'h0, sp});
         check("forced_active", {31'h0, forced_speed_active},
               {31'h0, sp != 2'h3});
         rd("control_speed", CTL, ctl, 1'b0);
      end
      wr(CTL, 32'h0000_3000, 1'b0);
      settle();
      check("autoneg_on", {31'h0, autoneg_enable}, 32'h1);
      check("forced_ignored", {31'h0, forced_speed_active}, 32'h0);
      rd("control_autoneg", CTL, 32'h0000_3000, 1'b0);
      $display("test speed_select done");
      p0 = pulses;
      wr(CTL, 32'h0000_c040, 1'b0);
      repeat (3) @(posedge pclk);
      check("reset_pulses", pulses - p0, 32'h1);
      check("loopback_on", {31'h0, local_loopback}, 32'h1);
      check("autoneg_off", {31'h0, autoneg_enable}, 32'h0);
      rd("control_selfclear", CTL, 32'h0000_4040, 1'b0);
      wr(CTL, 32'h0000_0040, 1'b0);
      settle();
      check("loopback_off", {31'h0, local_loopback}, 32'h0);
      check("no_reset_pulse", pulses - p0, 32'h1);
      $display("test soft_reset_loopback done");
      ce <= 1'b0;
      fork
         wr(CTL, 32'h0000_4040, 1'b0);
         begin
            repeat (6) @(posedge pclk);
            check("frozen_loopback", {31'h0, local_loopback}, 32'h0);
            check("frozen_ready", {31'h0, pready}, 32'h0);
            ce <= 1'b1;
         end
      join
      settle();
      check("ce_loopback", {31'h0, local_loopback}, 32'h1);
      wr(CTL, 32'h0000_0040, 1'b0);
      $display("test clock_enable done");
      for (int i = 0; i < 16; i++) begin
         b = i[3:0];
         link_speed <= 2'(i % 3);
         link_duplex <= b[2];
         link_up <= b[0] | b[3];
         adv_pause <= {b[3], b[1]};
         pause_agreed_tx <= b[2] | b[0];
         pause_agreed_rx <= ~b[1];
         rd("copper_status", STS, {27'h0, 2'(i % 3), b[2],
            (b[3] | b[1]) & (b[0] | b[3]) & (b[2] | b[0]),
            (b[3] | b[1]) & (b[0] | b[3]) & ~b[1]}, 1'b0);
      end
      wr(STS, 32'hffff_ffff, 1'b0);
      rd("status_after_write", STS, {27'h0, 2'h0, 1'b1, 1'b1, 1'b0},
         1'b0);
      $display("test copper_status done");
      copper_port <= 1'b0;
      repeat (4) @(posedge pclk);
      for (int j = 0; j < 8; j++) begin
         b = j[3:0];
         pif_a <= {1'b1, b[0], b[1], b[2], b[0] ^ b[1], 3'b101};
         pif_b <= {1'b0, b[1] ^ b[2], 6'h2a};
         rd("parallel_status", STS, {27'h0, b[1] ^ b[2], b[2], b[0], b[1],
            b[0] ^ b[1]}, 1'b0);
      end
      rd("control_absent", CTL, 32'h0, 1'b1);
      wr(CTL, 32'h0000_4000, 1'b1);
      rd("unmapped", 12'h104, 32'h0, 1'b1);
      copper_port <= 1'b1;
      repeat (4) @(posedge pclk);
      rd("control_kept", CTL, 32'h0000_0040, 1'b0);
      $display("test parallel_status done");
      strap_autoneg <= 1'b1;
      strap_speed <= 2'h1;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      check("reset_speed", {30'h0, forced_speed}, 32'h0);
      presetn <= 1'b1;
      repeat (8) @(posedge pclk);
      rd("control_restrap", CTL, 32'h0000_3000, 1'b0);
      check("autoneg_strap", {31'h0, autoneg_enable}, 32'h1);
      check("speed_strap", {30'h0, forced_speed}, 32'h1);
      check("strap_inactive", {31'h0, forced_speed_active}, 32'h0);
      $display("test strap_reload done");
      end_of_test();
   end
endmodule : port_status_copper_basic_control_tb_top
